// ### hdl/clock_channel_divider_config.sv
// Two output-clock channel dividers with APB configuration registers
`timescale 1ns/1ps
module clock_channel_divider_config
   import clock_div_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic syncPin,
   input wire logic oscPin,
   input wire logic extClkPin,
   output logic firstChannelOutputA,
   output logic firstChannelOutputB,
   output logic secondStageOneOut,
   output logic secondChannelOut
);
   // ---------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------
   logic [2:0] pinSync;
   logic syncLvl;
   logic oscLvl;
   logic extLvl;

   sync2 #(.W(3)) u_pins (
      .clk(clk),
      .rst(rst),
      .din({syncPin, oscPin, extClkPin}),
      .dout(pinSync)
   );

   assign syncLvl = pinSync[2];
   assign oscLvl = pinSync[1];
   assign extLvl = pinSync[0];

   // ---------------------------------------------
   // APB slave
   // ---------------------------------------------
   logic [7:0] regs_q [0:NUM_REGS-1];
   logic [1:0] srcSel_q;
   logic [31:0] prdata_q;
   logic slvErr_q;
   logic [3:0] status;

   wire [9:0] wordIdx = paddr[11:2];
   wire inArray = (wordIdx >= IDX_CYC1) && (wordIdx <= IDX_CTL2);
   wire [9:0] slotWide = wordIdx - IDX_CYC1;
   wire [2:0] slot = slotWide[2:0];
   wire isSrc = (wordIdx == IDX_SRC_SEL);
   wire isStatus = (wordIdx == IDX_STATUS);
   wire mapped = inArray | isSrc | isStatus;
   wire setupPhase = psel & ~penable;
   wire wrEn = psel & penable & pwrite;
   wire [31:0] rdMux = inArray ? {24'h000000, regs_q[slot]} :
                       isSrc ? {30'h00000000, srcSel_q} :
                       isStatus ? {28'h0000000, status} : 32'h00000000;

   // Zero wait states; answer is staged during setup
   assign pready = 1'b1;
   assign prdata = prdata_q;
   assign pslverr = slvErr_q & psel & penable;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         prdata_q <= 32'h00000000;
         slvErr_q <= 1'b0;
      end
      else if (setupPhase)
      begin
         prdata_q <= pwrite ? 32'h00000000 : rdMux;
         slvErr_q <= ~mapped;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_REGS; gi++)
      begin : g_regs
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
               regs_q[gi] <= REG_RST;
            else if (wrEn && inArray && slot == 3'(gi))
               regs_q[gi] <= pwdata[7:0];
         end
      end
   endgenerate

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         srcSel_q <= SRC_RST;
      else if (wrEn && isSrc)
         srcSel_q <= pwdata[1:0];
   end

   // ---------------------------------------------
   // Field decode
   // ---------------------------------------------
   wire [7:0] cyc1 = regs_q[SLOT_CYC1];
   wire [7:0] ctl1 = regs_q[SLOT_CTL1];
   wire [7:0] rte1 = regs_q[SLOT_RTE1];
   wire [7:0] s1Cnt = regs_q[SLOT_S1CNT];
   wire [7:0] phase2 = regs_q[SLOT_PHASE2];
   wire [7:0] s2Cnt = regs_q[SLOT_S2CNT];
   wire [7:0] ctl2 = regs_q[SLOT_CTL2];

   // ---------------------------------------------
   // Divider input reference
   // ---------------------------------------------
   // Half-rate level so a bypassed stage has a real clock to pass
   logic refClk_q;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         refClk_q <= 1'b0;
      else
         refClk_q <= ~refClk_q;
   end

   wire refRise = ~refClk_q;

   // ---------------------------------------------
   // Duty-cycle correction
   // ---------------------------------------------
   // raw counts from the cycle-count register
   wire [3:0] rawLow = cyc1[7:4];
   wire [3:0] rawHigh = cyc1[3:0];
   wire [5:0] total = 6'(rawLow) + 6'(rawHigh) + 6'h02;
   wire [5:0] halfTot = {1'b0, total[5:1]};
   wire [5:0] balHigh = halfTot - 6'h01;
   wire [5:0] balLow = total - halfTot - 6'h01;
   // bit clear balances the halves, bit set keeps raw counts
   wire dccOn = ~rte1[BIT_DCC_OFF];
   wire [3:0] effLow = dccOn ? balLow[3:0] : rawLow;
   wire [3:0] effHigh = dccOn ? balHigh[3:0] : rawHigh;

   // ---------------------------------------------
   // First divider
   // ---------------------------------------------
   logic div1Out;

   div_stage u_div1 (
      .clk(clk),
      .rst(rst),
      .inClk(refClk_q),
      .inRise(refRise),
      .lowCnt(effLow),
      .highCnt(effHigh),
      .bypass(ctl1[BIT_BYPASS1]),
      .ignoreSync(ctl1[BIT_NOSYNC1]),
      .syncLvl(syncLvl),
      .startHigh(ctl1[BIT_START1]),
      .phase(ctl1[3:0]),
      .outClk(div1Out),
      .outRise()
   );

   // forced level only holds when sync is being ignored
   wire forced = ctl1[BIT_NOSYNC1] & syncLvl;
   wire divLvl = forced ? ctl1[BIT_FORCE1] : div1Out;

   // direct route from oscillator or external clock
   wire routeOn = rte1[BIT_ROUTE];
   wire pairLvl = !routeOn ? divLvl :
                  (srcSel_q == SRC_OSC) ? oscLvl :
                  (srcSel_q == SRC_EXT) ? extLvl : divLvl;

   // ---------------------------------------------
   // Second channel, two cascaded stages
   // ---------------------------------------------
   logic s1Out;
   logic s1Rise;
   logic s2Out;
   // one sync-ignore bit serves both stages
   wire ignore2 = ctl2[BIT_NOSYNC2];

   // stage one counts, low phase nibble, bypass
   div_stage u_s1 (
      .clk(clk),
      .rst(rst),
      .inClk(refClk_q),
      .inRise(refRise),
      .lowCnt(s1Cnt[7:4]),
      .highCnt(s1Cnt[3:0]),
      .bypass(ctl2[BIT_BYPASS_S1]),
      .ignoreSync(ignore2),
      .syncLvl(syncLvl),
      .startHigh(1'b0),
      .phase(phase2[3:0]),
      .outClk(s1Out),
      .outRise(s1Rise)
   );

   // stage two clocked by stage one output
   div_stage u_s2 (
      .clk(clk),
      .rst(rst),
      .inClk(s1Out),
      .inRise(s1Rise),
      .lowCnt(s2Cnt[7:4]),
      .highCnt(s2Cnt[3:0]),
      .bypass(ctl2[BIT_BYPASS_S2]),
      .ignoreSync(ignore2),
      .syncLvl(syncLvl),
      .startHigh(1'b0),
      .phase(phase2[7:4]),
      .outClk(s2Out),
      .outRise()
   );

   // ---------------------------------------------
   // Output registers
   // ---------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         firstChannelOutputA <= 1'b0;
         firstChannelOutputB <= 1'b1;
         secondStageOneOut <= 1'b0;
         secondChannelOut <= 1'b0;
      end
      else
      begin
         firstChannelOutputA <= pairLvl;
         firstChannelOutputB <= ~pairLvl;
         secondStageOneOut <= s1Out;
         secondChannelOut <= s2Out;
      end
   end

   assign status = {syncLvl, secondChannelOut, secondStageOneOut, firstChannelOutputA};

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   property p_routeDiv;
      @(posedge clk) disable iff (rst)
      !routeOn && !forced |=> firstChannelOutputA == $past(div1Out)
         && firstChannelOutputB == !$past(div1Out);
   endproperty
   a_routeDiv: assert property (p_routeDiv) else $error("pair not fed by divider");

   property p_routeSrc;
      @(posedge clk) disable iff (rst)
      routeOn && srcSel_q != 2'h1 && srcSel_q != 2'h3 |=>
         firstChannelOutputA == ($past(srcSel_q) == SRC_OSC ? $past(oscLvl) : $past(extLvl));
   endproperty
   a_routeSrc: assert property (p_routeSrc) else $error("direct route source wrong");

   property p_force;
      @(posedge clk) disable iff (rst)
      !routeOn && ctl1[BIT_NOSYNC1] && syncLvl |=> firstChannelOutputA == $past(ctl1[BIT_FORCE1]);
   endproperty
   a_force: assert property (p_force) else $error("forced level not applied");

   property p_dcc;
      @(posedge clk) disable iff (rst)
      dccOn |-> (effLow == effHigh) || (effLow == effHigh + 4'h1);
   endproperty
   a_dcc: assert property (p_dcc) else $error("duty correction unbalanced");

   property p_cascade;
      @(posedge clk) disable iff (rst)
      ctl2[BIT_BYPASS_S2] && !ctl2[BIT_BYPASS_S1] |=> secondChannelOut == $past(s1Out);
   endproperty
   a_cascade: assert property (p_cascade) else $error("stage two not fed by stage one");

   // ---------------------------------------------
   // Output and register path checks
   // ---------------------------------------------
   property p_pairComp;
      @(posedge clk) disable iff (rst)
      firstChannelOutputB == !firstChannelOutputA;
   endproperty
   a_pairComp: assert property (p_pairComp) else $error("pair not complementary");

   property p_bypass1;
      @(posedge clk) disable iff (rst)
      ctl1[BIT_BYPASS1] && !routeOn && !forced |=> firstChannelOutputA == $past(refClk_q);
   endproperty
   a_bypass1: assert property (p_bypass1) else $error("bypass not passing input");

   // Start level shows one edge after restart, output register adds one
   property p_startHeld;
      @(posedge clk) disable iff (rst)
      !ctl1[BIT_NOSYNC1] && syncLvl && $past(!ctl1[BIT_NOSYNC1] && syncLvl)
         && !routeOn && !ctl1[BIT_BYPASS1] |=> firstChannelOutputA == $past(ctl1[BIT_START1], 2);
   endproperty
   a_startHeld: assert property (p_startHeld) else $error("held level not start level");

   property p_rawCounts;
      @(posedge clk) disable iff (rst)
      !dccOn |-> effLow == rawLow && effHigh == rawHigh;
   endproperty
   a_rawCounts: assert property (p_rawCounts) else $error("raw counts altered");

   // Correction must move cycles between halves, never change the period
   property p_dccPeriod;
      @(posedge clk) disable iff (rst)
      dccOn |-> 6'(effLow) + 6'(effHigh) == 6'(rawLow) + 6'(rawHigh);
   endproperty
   a_dccPeriod: assert property (p_dccPeriod) else $error("duty correction changed period");

   property p_bypassS1;
      @(posedge clk) disable iff (rst)
      ctl2[BIT_BYPASS_S1] |=> secondStageOneOut == $past(refClk_q);
   endproperty
   a_bypassS1: assert property (p_bypassS1) else $error("stage one bypass wrong");

   property p_bypassS2;
      @(posedge clk) disable iff (rst)
      ctl2[BIT_BYPASS_S2] |=> secondChannelOut == $past(s1Out);
   endproperty
   a_bypassS2: assert property (p_bypassS2) else $error("stage two bypass wrong");

   property p_sync2Hold;
      @(posedge clk) disable iff (rst)
      !ignore2 && syncLvl && $past(!ignore2 && syncLvl) && !ctl2[BIT_BYPASS_S1]
         |=> secondStageOneOut == 1'b0;
   endproperty
   a_sync2Hold: assert property (p_sync2Hold) else $error("stage one not held by sync");

   property p_readBack;
      @(posedge clk) disable iff (rst)
      setupPhase && !pwrite && inArray |=> prdata == {24'h000000, $past(regs_q[slot])};
   endproperty
   a_readBack: assert property (p_readBack) else $error("register read data wrong");
endmodule

// ### hdl/clock_div_pkg.sv
// Constants shared by the two-channel clock divider block
// Function
// - First divider output stays low for upper-nibble count of input cycles.
// - First divider output stays high for lower-nibble count of input cycles.
// - First divider bypass bit set powers divider down and passes input clock.
// - First divider obeys chip sync when sync-ignore is 0, ignores when 1.
// - Force bit sets forced output level; software must also set sync-ignore.
// - Start-level bit selects whether first divider output begins high or low.
// - Four-bit phase offset in control low nibble sets first divider phase.
// - Direct-route bit 0 connects both pair outputs to the first divider.
// - Direct-route 1 takes oscillator on 10b, external clock on 00b, unchanged 01b.
// - Duty-correction bit 0 enables correction, 1 disables it.
// - Second channel stage one stays low for upper-nibble count.
// - Second channel stage one stays high for lower-nibble count.
// - Stage two stays low for upper nibble, high for lower nibble counts.
// - Phase register holds stage two offset high, stage one offset low.
// - Stage two bypass bit 1 powers its divider down and passes input.
// - Stage one bypass bit 1 powers its divider down and passes input.
// - Second channel sync-ignore 0 makes both stages obey chip sync.
// - Second channel sync-ignore 1 makes both stages ignore chip sync.
package clock_div_pkg;
   // Register word indices; byte address is four times the index
   localparam logic [9:0] IDX_CYC1 = 10'h196;
   localparam logic [9:0] IDX_CTL1 = 10'h197;
   localparam logic [9:0] IDX_RTE1 = 10'h198;
   localparam logic [9:0] IDX_S1CNT = 10'h199;
   localparam logic [9:0] IDX_PHASE2 = 10'h19a;
   localparam logic [9:0] IDX_S2CNT = 10'h19b;
   localparam logic [9:0] IDX_CTL2 = 10'h19c;
   localparam logic [9:0] IDX_SRC_SEL = 10'h1e1;
   localparam logic [9:0] IDX_STATUS = 10'h1f0;
   localparam int NUM_REGS = 7;
   // Slots in the register array
   localparam logic [2:0] SLOT_CYC1 = 3'h0;
   localparam logic [2:0] SLOT_CTL1 = 3'h1;
   localparam logic [2:0] SLOT_RTE1 = 3'h2;
   localparam logic [2:0] SLOT_S1CNT = 3'h3;
   localparam logic [2:0] SLOT_PHASE2 = 3'h4;
   localparam logic [2:0] SLOT_S2CNT = 3'h5;
   localparam logic [2:0] SLOT_CTL2 = 3'h6;
   // Field positions
   localparam int BIT_BYPASS1 = 7;
   localparam int BIT_NOSYNC1 = 6;
   localparam int BIT_FORCE1 = 5;
   localparam int BIT_START1 = 4;
   localparam int BIT_ROUTE = 1;
   localparam int BIT_DCC_OFF = 0;
   localparam int BIT_BYPASS_S2 = 5;
   localparam int BIT_BYPASS_S1 = 4;
   localparam int BIT_NOSYNC2 = 3;
   // Source select codes
   localparam logic [1:0] SRC_OSC = 2'h2;
   localparam logic [1:0] SRC_EXT = 2'h0;
   // Reset values
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [1:0] SRC_RST = 2'h1;
endpackage

// ### hdl/sync2.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 3
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_q <= '0;
         dout <= '0;
      end
      else
      begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule

// ### hdl/div_stage.sv
// One divider stage: low/high counts, phase hold-off, sync restart, bypass
`timescale 1ns/1ps
module div_stage
   import clock_div_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic inClk,
   input wire logic inRise,
   input wire logic [3:0] lowCnt,
   input wire logic [3:0] highCnt,
   input wire logic bypass,
   input wire logic ignoreSync,
   input wire logic syncLvl,
   input wire logic startHigh,
   input wire logic [3:0] phase,
   output logic outClk,
   output logic outRise
);
   logic [3:0] cnt_q;
   logic [3:0] wait_q;
   logic level_q;

   wire restart = syncLvl & ~ignoreSync;
   wire waiting = (wait_q != 4'h0);
   wire [3:0] limit = level_q ? highCnt : lowCnt;
   wire segEnd = inRise & ~waiting & (cnt_q == limit);

   // ---------------------------------------------
   // Counter
   // ---------------------------------------------
   // bypass idles, sync restarts at start level
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_q <= 4'h0;
         wait_q <= 4'h0;
         level_q <= 1'b0;
      end
      else if (bypass)
      begin
         cnt_q <= 4'h0;
         wait_q <= 4'h0;
         level_q <= startHigh;
      end
      else if (restart)
      begin
         cnt_q <= 4'h0;
         wait_q <= phase;
         level_q <= startHigh;
      end
      else if (inRise)
      begin
         if (waiting)
            wait_q <= wait_q - 4'h1;
         // toggle after count plus one cycles
         else if (segEnd)
         begin
            level_q <= ~level_q;
            cnt_q <= 4'h0;
         end
         else
            cnt_q <= cnt_q + 4'h1;
      end
   end

   assign outClk = bypass ? inClk : level_q;
   // Tick one cycle ahead of the rising output, feeds a cascade
   assign outRise = bypass ? inRise : (segEnd & ~level_q & ~restart);

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   property p_lowLen;
      @(posedge clk) disable iff (rst)
      $rose(level_q) && !$past(restart) && !$past(bypass) |-> $past(cnt_q) == $past(lowCnt);
   endproperty
   a_lowLen: assert property (p_lowLen) else $error("low phase length wrong");

   property p_highLen;
      @(posedge clk) disable iff (rst)
      $fell(level_q) && !$past(restart) && !$past(bypass) |-> $past(cnt_q) == $past(highCnt);
   endproperty
   a_highLen: assert property (p_highLen) else $error("high phase length wrong");

   property p_bypassIdle;
      @(posedge clk) disable iff (rst)
      bypass |=> cnt_q == 4'h0 && wait_q == 4'h0;
   endproperty
   a_bypassIdle: assert property (p_bypassIdle) else $error("bypassed divider not idle");

   property p_syncRestart;
      @(posedge clk) disable iff (rst)
      restart && !bypass |=> level_q == $past(startHigh) && cnt_q == 4'h0;
   endproperty
   a_syncRestart: assert property (p_syncRestart) else $error("sync restart wrong");

   property p_ignoreSync;
      @(posedge clk) disable iff (rst)
      ignoreSync && syncLvl && !bypass && !inRise |=> $stable(level_q);
   endproperty
   a_ignoreSync: assert property (p_ignoreSync) else $error("ignored sync moved output");

   property p_phaseHold;
      @(posedge clk) disable iff (rst)
      $fell(restart) && !bypass && !$past(bypass) |-> wait_q == $past(phase);
   endproperty
   a_phaseHold: assert property (p_phaseHold) else $error("phase hold-off wrong");

   property p_phaseWait;
      @(posedge clk) disable iff (rst)
      waiting && !bypass && !restart |=> $stable(level_q);
   endproperty
   a_phaseWait: assert property (p_phaseWait) else $error("output moved in hold-off");
endmodule

// ### tb/clock_channel_divider_config_tb.sv
// Self-checking testbench for the two-channel clock divider block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module clock_channel_divider_config_tb;
   import clock_div_pkg::*;
   logic clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic syncPin, oscPin, extClkPin;
   logic outA, outB, stageOne, chanTwo;
   int bad_count = 0;
   int n_compared = 0;
   clock_channel_divider_config u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .syncPin(syncPin), .oscPin(oscPin), .extClkPin(extClkPin),
      .firstChannelOutputA(outA), .firstChannelOutputB(outB),
      .secondStageOneOut(stageOne), .secondChannelOut(chanTwo));
   // ----------------------------------------
   // Closing report
   // ----------------------------------------
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ----------------------------------------
   // Bus and measurement helpers
   // ----------------------------------------
   task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] wd,
      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
      begin
         bad_count++;
         stop_test();
      end
   endtask
   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, idx, d, r, e);
   endtask
   function automatic logic outSel(input int s);
      case (s)
         0: return outA;
         1: return outB;
         2: return stageOne;
         default: return chanTwo;
      endcase
   endfunction
   task automatic waitLvl(input int s, input logic v);
      int n;
      n = 0;
      while (outSel(s) !== v && n < 300)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 300)
      begin
         bad_count++;
         stop_test();
      end
   endtask
   // Skips one period so a register change has settled before counting
   task automatic measure(input int s, input int expHi, input int expLo);
      int hi, lo;
      hi = 0;
      lo = 0;
      waitLvl(s, 1'b0);
      waitLvl(s, 1'b1);
      waitLvl(s, 1'b0);
      waitLvl(s, 1'b1);
      while (outSel(s) === 1'b1 && hi < 300)
      begin
         @(negedge clk);
         hi++;
         `CHK("pair complement", ~outA, outB)
      end
      while (outSel(s) === 1'b0 && lo < 300)
      begin
         @(negedge clk);
         lo++;
      end
      `CHK("high clocks", expHi, hi)
      `CHK("low clocks", expLo, lo)
   endtask
   // Holds sync, checks the held level, then times the first rise after release
   task automatic firstRise(input int s, input logic held, output int t);
      @(posedge clk);
      syncPin <= 1'b1;
      repeat (8) @(negedge clk);
      `CHK("held level", held, outSel(s))
      @(posedge clk);
      syncPin <= 1'b0;
      t = 0;
      while (outSel(s) !== 1'b1 && t < 300)
      begin
         @(negedge clk);
         t++;
      end
      if (t >= 300)
         bad_count++;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      logic [9:0] idx [7] = '{IDX_CYC1, IDX_CTL1, IDX_RTE1, IDX_S1CNT, IDX_PHASE2,
         IDX_S2CNT, IDX_CTL2};
      logic [31:0] r;
      logic e;
      `CHK("reset A", 1'b0, outA)
      `CHK("reset B", 1'b1, outB)
      apb(1'b0, IDX_SRC_SEL, 8'h00, r, e);
      `CHK("source reset", {30'h0, SRC_RST}, r)
      foreach (idx[i])
      begin
         apb(1'b0, idx[i], 8'h00, r, e);
         `CHK("reg reset", {24'h0, REG_RST}, r)
         wr(idx[i], 8'ha5 ^ 8'(i));
         apb(1'b0, idx[i], 8'h00, r, e);
         `CHK("reg readback", {24'h0, 8'ha5 ^ 8'(i)}, r)
         `CHK("reg no error", 1'b0, e)
         wr(idx[i], 8'h00);
      end
      apb(1'b0, 10'h3ff, 8'h00, r, e);
      `CHK("unmapped error", 1'b1, e)
      `CHK("unmapped data", 32'h0, r)
   endtask
   task automatic t_div1();
      wr(IDX_RTE1, 8'h01);
      wr(IDX_CYC1, 8'h31);
      measure(0, 4, 8);
      wr(IDX_RTE1, 8'h00);
      measure(0, 6, 6);
      wr(IDX_RTE1, 8'h01);
      wr(IDX_CTL1, 8'h80);
      measure(0, 1, 1);
   endtask
   task automatic t_force();
      wr(IDX_CTL1, 8'h60);
      syncPin <= 1'b1;
      repeat (8) @(negedge clk);
      repeat (6)
      begin
         @(negedge clk);
         `CHK("forced high", 1'b1, outA)
      end
      wr(IDX_CTL1, 8'h40);
      repeat (8) @(negedge clk);
      `CHK("forced low", 1'b0, outA)
      @(posedge clk);
      syncPin <= 1'b0;
      wr(IDX_CTL1, 8'h00);
   endtask
   task automatic t_route();
      wr(IDX_RTE1, 8'h03);
      for (int k = 0; k < 4; k++)
      begin
         wr(IDX_SRC_SEL, k[1] ? SRC_OSC : SRC_EXT);
         @(posedge clk);
         oscPin <= k[1] ~^ k[0];
         extClkPin <= k[1] ^ k[0];
         repeat (8) @(negedge clk);
         `CHK("direct route", k[0] ? 1'b1 : 1'b0, outA)
         `CHK("direct route B", k[0] ? 1'b0 : 1'b1, outB)
      end
      wr(IDX_SRC_SEL, 8'h01);
      measure(0, 4, 8);
      wr(IDX_RTE1, 8'h01);
   endtask
   task automatic t_ch2();
      wr(IDX_S1CNT, 8'h10);
      wr(IDX_S2CNT, 8'h01);
      measure(2, 2, 4);
      measure(3, 12, 6);
      wr(IDX_CTL2, 8'h20);
      measure(3, 2, 4);
      wr(IDX_CTL2, 8'h10);
      measure(2, 1, 1);
      measure(3, 4, 2);
      wr(IDX_CTL2, 8'h00);
   endtask
   task automatic t_sync();
      int t0, t1;
      wr(IDX_CTL1, 8'h10);
      firstRise(0, 1'b1, t0);
      wr(IDX_CTL1, 8'h00);
      firstRise(0, 1'b0, t0);
      // Repeat so both timed releases share the reference phase
      wr(IDX_CTL1, 8'h00);
      firstRise(0, 1'b0, t0);
      wr(IDX_CTL1, 8'h03);
      firstRise(0, 1'b0, t1);
      `CHK("first phase delta", 6, t1 - t0)
      firstRise(2, 1'b0, t0);
      firstRise(3, 1'b0, t0);
      wr(IDX_PHASE2, 8'h00);
      firstRise(2, 1'b0, t0);
      wr(IDX_PHASE2, 8'h02);
      firstRise(2, 1'b0, t1);
      `CHK("stage one phase delta", 4, t1 - t0)
      wr(IDX_CTL2, 8'h08);
      @(posedge clk);
      syncPin <= 1'b1;
      measure(2, 2, 4);
      @(posedge clk);
      syncPin <= 1'b0;
   endtask
   // ----------------------------------------
   // Clock, reset and main sequence
   // ----------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial
   begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      syncPin = 1'b0;
      oscPin = 1'b0;
      extClkPin = 1'b0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      t_regs();
      t_div1();
      t_force();
      t_route();
      t_ch2();
      t_sync();
      stop_test();
   end
endmodule
